// ---- dv/smcg_core_model.sv ----
// Core-side model that issues the sleep instruction
`timescale 1ns/1ps
module smcg_core_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd,
    input wire logic permit_on,
    input wire logic core_halted,
    output logic sleep_req,
    output logic sleep_permit_bit
);
    // ----------------------------------------------------------------
    // Sleep instruction issue
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sleep_req <= 1'b0;
            sleep_permit_bit <= 1'b0;
        end else begin
            // Halted core executes nothing
            sleep_req <= cmd & ~core_halted & ~sleep_req;
            // Permit follows cmd while permit_on is set; unlike the sleep request it ignores core_halted and is not one-shot
            sleep_permit_bit <= cmd & permit_on;
        end
    end
endmodule

// ---- dv/smcg_sleep_ctrl_bench.sv ----
// Self-checking bench for the sleep-mode controller
`timescale 1ns/1ps
module smcg_sleep_ctrl_bench;
    logic clk, sys_rst, cmd, permit_on, sleep_req, sleep_permit_bit, xtal;
    logic as_sel, adc, cmp, cmp_vref, bod, wdt;
    logic [2:0] sel;
    smcg_pkg::smcg_wake_t wake_src;
    smcg_pkg::smcg_clk_t clk_en;
    smcg_pkg::smcg_ana_t ana_en;
    logic main_osc, tosc, ibuf, halted, wpulse, long_conv, undef, wpbuf;
    int n_mismatch = 0;
    int n_tests = 0;
    localparam logic [2:0] MD [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    localparam logic [4:0] CK [6] = '{5'h07, 5'h03, 5'h00, 5'h01,
        5'h00, 5'h01};
    localparam logic [5:0] OSC = 6'h33;
    localparam logic [5:0] TOSC = 6'h2b;
    localparam logic [5:0] BUF = 6'h03;
    localparam int WC [6] = '{6, 6, 16, 16, 6, 6};

    smcg_core_model u_core (.clk(clk), .sys_rst(sys_rst), .cmd(cmd),
        .permit_on(permit_on), .core_halted(halted), .sleep_req(sleep_req),
        .sleep_permit_bit(sleep_permit_bit));
    smcg_sleep_ctrl u_dut (.clk(clk), .sys_rst(sys_rst),
        .sleep_req(sleep_req), .sleep_permit_bit(sleep_permit_bit),
        .sleep_mode_select(sel), .xtal_clock_sel(xtal),
        .async_timer_clock_select(as_sel), .wake_src(wake_src),
        .adc_enable(adc), .cmp_enable(cmp), .cmp_uses_vref(cmp_vref),
        .brownout_enable_fuse(bod), .wdt_enable(wdt), .clk_en(clk_en),
        .main_osc_en(main_osc), .timer_osc_en(tosc), .ana_en(ana_en),
        .input_buf_en(ibuf), .wake_pin_buf_en(wpbuf), .core_halted(halted),
        .wake_pulse(wpulse), .adc_long_conv(long_conv),
        .async_timer_undef(undef));

    // ----------------------------------------------------------------
    // Common tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic enter(input logic [2:0] m);
        sel = m;
        cmd = 1'b1;
        step(1);
        cmd = 1'b0;
        step(2);
    endtask

    task automatic wake(input int b, input int exp);
        int n;
        n = 0;
        wake_src = smcg_pkg::smcg_wake_t'(10'h001 << b);
        while (wpulse !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        if (n == 40) begin
            n_mismatch++;
            print_verdict();
        end
        chk("wake cycles", 16'(n), 16'(exp));
        wake_src = '0;
        step(1);
        chk("halted after wake", halted, 1'b0);
    endtask

    task automatic no_wake(input int b);
        wake_src = smcg_pkg::smcg_wake_t'(10'h001 << b);
        step(3);
        chk("unqualified wake", halted, 1'b1);
        wake_src = '0;
        step(1);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_modes();
        xtal = 1'b1;
        as_sel = 1'b1;
        for (int i = 0; i < 6; i++) begin
            enter(MD[i]);
            chk("halted", halted, 1'b1);
            chk("clk_en", clk_en, CK[i]);
            chk("main_osc", main_osc, OSC[i]);
            chk("timer_osc", tosc, TOSC[i]);
            chk("input_buf", ibuf, BUF[i]);
            chk("wake_pin_buf", wpbuf, 1'b1);
            wake(4, WC[i]);
        end
    endtask

    task automatic t_refuse();
        enter(3'h4);
        chk("reserved 4", halted, 1'b0);
        enter(3'h5);
        chk("reserved 5", halted, 1'b0);
        xtal = 1'b0;
        enter(3'h6);
        chk("standby no xtal", halted, 1'b0);
        xtal = 1'b1;
        permit_on = 1'b0;
        enter(3'h0);
        chk("no permit", {halted, clk_en}, 16'h001f);
        permit_on = 1'b1;
    endtask

    task automatic t_sources();
        enter(3'h2);
        no_wake(7);
        no_wake(0);
        wake(8, 16);
        enter(3'h1);
        no_wake(0);
        wake(2, 6);
        as_sel = 1'b0;
        enter(3'h3);
        no_wake(3);
        wake(5, 16);
        chk("async undef", undef, 1'b1);
    endtask

    task automatic t_analog();
        {adc, cmp, cmp_vref, bod, wdt} = 5'h1f;
        // Mid-run reset with converter held on: no restart seen after it
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        step(1);
        chk("reset state", {halted, clk_en}, 16'h001f);
        chk("undef after reset", undef, 1'b0);
        chk("no long conv", long_conv, 1'b0);
        enter(3'h2);
        chk("ana deep", ana_en, 5'h17);
        wake(4, 16);
        enter(3'h0);
        chk("ana idle", ana_en, 5'h1f);
        wake(4, 6);
        adc = 1'b0;
        step(2);
        adc = 1'b1;
        step(2);
        chk("long conv", long_conv, 1'b1);
        // Comparator alone on the reference, deep sleep
        {adc, cmp, cmp_vref, bod, wdt} = 5'h0c;
        enter(3'h2);
        chk("vref for cmp", ana_en, 5'h02);
        wake(4, 16);
        {adc, cmp, cmp_vref, bod, wdt} = 5'h00;
        step(1);
        chk("vref off", ana_en, 5'h00);
    endtask

    // ----------------------------------------------------------------
    // Clock, reset and sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #1ms;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        {cmd, xtal, as_sel, adc, cmp, cmp_vref, bod, wdt} = '0;
        permit_on = 1'b1;
        sel = 3'h0;
        wake_src = '0;
        step(20);
        sys_rst = 1'b0;
        step(1);
        t_modes();
        t_refuse();
        t_sources();
        t_analog();
        print_verdict();
    end
endmodule

// ---- rtl/smcg_pkg.sv ----
// Package: mode codes, carrier structs and timing for the sleep controller
package smcg_pkg;

    localparam logic [2:0] SMCG_MODE_IDLE = 3'h0;
    localparam logic [2:0] SMCG_MODE_NOISE = 3'h1;
    localparam logic [2:0] SMCG_MODE_PDOWN = 3'h2;
    localparam logic [2:0] SMCG_MODE_PSAVE = 3'h3;
    localparam logic [2:0] SMCG_MODE_RSV4 = 3'h4;
    localparam logic [2:0] SMCG_MODE_RSV5 = 3'h5;
    localparam logic [2:0] SMCG_MODE_STBY = 3'h6;
    localparam logic [2:0] SMCG_MODE_XSTBY = 3'h7;

    // Standby wake-up length in main clock cycles
    localparam int SMCG_STBY_WAKE_CYC = 6;
    localparam logic [2:0] SMCG_STBY_WAKE_CNT = 3'(SMCG_STBY_WAKE_CYC);
    // Oscillator restart delay after power-down and power-save, fixed here
    localparam int SMCG_OSC_WAKE_CYC = 16;
    localparam logic [4:0] SMCG_OSC_WAKE_CNT = 5'(SMCG_OSC_WAKE_CYC);

    typedef enum logic [1:0] {
        SMCG_RUN,
        SMCG_SLEEP,
        SMCG_WAKE
    } smcg_state_t;

    // Wake-up sources as presented to the controller
    typedef struct packed {
        logic ext_irq_a_level;
        logic ext_irq_b_level;
        logic ext_irq_a_edge;
        logic ext_irq_b_edge;
        logic ext_irq_c;
        logic twi_addr_match;
        logic timer2_irq;
        logic nvm_ready;
        logic adc_done;
        logic other_io;
    } smcg_wake_t;

    // Clock domain enables
    typedef struct packed {
        logic core_clock;
        logic program_memory_clock;
        logic peripheral_io_clock;
        logic converter_clock;
        logic async_timer_clock;
    } smcg_clk_t;

    // Analog helper controls
    typedef struct packed {
        logic adc_on;
        logic cmp_on;
        logic bod_on;
        logic vref_on;
        logic wdt_on;
    } smcg_ana_t;

    typedef struct packed {
        smcg_state_t state;
        logic [2:0] mode;
        logic [4:0] cnt;
        logic adc_was_off;
        logic adc_long_conv;
        logic async_undef;
    } smcg_regs_t;

endpackage

// ---- rtl/smcg_sleep_ctrl.sv ----
// Sleep-mode clock gating controller
`timescale 1ns/1ps
module smcg_sleep_ctrl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sleep_req,
    input wire logic sleep_permit_bit,
    input wire logic [2:0] sleep_mode_select,
    input wire logic xtal_clock_sel,
    input wire logic async_timer_clock_select,
    input wire smcg_pkg::smcg_wake_t wake_src,
    input wire logic adc_enable,
    input wire logic cmp_enable,
    input wire logic cmp_uses_vref,
    input wire logic brownout_enable_fuse,
    input wire logic wdt_enable,
    output smcg_pkg::smcg_clk_t clk_en,
    output logic main_osc_en,
    output logic timer_osc_en,
    output smcg_pkg::smcg_ana_t ana_en,
    output logic input_buf_en,
    output logic wake_pin_buf_en,
    output logic core_halted,
    output logic wake_pulse,
    output logic adc_long_conv,
    output logic async_timer_undef
);

    smcg_pkg::smcg_regs_t r_r;
    smcg_pkg::smcg_regs_t r_nxt;

    // ------------------------------------------------------------
    // Mode decode helpers
    // ------------------------------------------------------------
    function automatic logic is_deep(input logic [2:0] m);
        return m != smcg_pkg::SMCG_MODE_IDLE &&
               m != smcg_pkg::SMCG_MODE_NOISE;
    endfunction

    function automatic logic is_async_mode(input logic [2:0] m);
        return m == smcg_pkg::SMCG_MODE_PSAVE ||
               m == smcg_pkg::SMCG_MODE_XSTBY;
    endfunction

    function automatic logic mode_legal(input logic [2:0] m,
                                        input logic xtal);
        logic ok;
        ok = 1'b1;
        unique case (m)
            smcg_pkg::SMCG_MODE_RSV4, smcg_pkg::SMCG_MODE_RSV5: ok = 1'b0;
            smcg_pkg::SMCG_MODE_STBY, smcg_pkg::SMCG_MODE_XSTBY: ok = xtal;
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    function automatic logic keep_osc(input logic [2:0] m);
        return !is_deep(m) || m == smcg_pkg::SMCG_MODE_STBY ||
               m == smcg_pkg::SMCG_MODE_XSTBY;
    endfunction

    logic sleeping;
    logic wake_ok;
    logic ext_wake;
    logic [2:0] m;

    assign sleeping = r_r.state == smcg_pkg::SMCG_SLEEP;
    assign m = r_r.mode;

    // ------------------------------------------------------------
    // Wake qualification
    // ------------------------------------------------------------
    always_comb begin
        ext_wake = wake_src.ext_irq_c | wake_src.ext_irq_a_level |
                   wake_src.ext_irq_b_level;
        if (m == smcg_pkg::SMCG_MODE_IDLE) begin
            ext_wake = ext_wake | wake_src.ext_irq_a_edge |
                       wake_src.ext_irq_b_edge;
        end
        wake_ok = ext_wake | wake_src.twi_addr_match;
        if (!is_deep(m)) begin
            wake_ok = wake_ok | wake_src.nvm_ready | wake_src.adc_done |
                      wake_src.timer2_irq;
        end
        if (is_async_mode(m) && async_timer_clock_select) begin
            wake_ok = wake_ok | wake_src.timer2_irq;
        end
        if (m == smcg_pkg::SMCG_MODE_IDLE) begin
            wake_ok = wake_ok | wake_src.other_io;
        end
    end

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    always_comb begin
        r_nxt = r_r;
        unique case (r_r.state)
            smcg_pkg::SMCG_RUN: begin
                if (sleep_req && sleep_permit_bit &&
                    mode_legal(sleep_mode_select, xtal_clock_sel)) begin
                    r_nxt.state = smcg_pkg::SMCG_SLEEP;
                    r_nxt.mode = sleep_mode_select;
                end
            end
            smcg_pkg::SMCG_SLEEP: begin
                if (wake_ok) begin
                    r_nxt.state = smcg_pkg::SMCG_WAKE;
                    r_nxt.cnt = keep_osc(m) ?
                        {2'h0, smcg_pkg::SMCG_STBY_WAKE_CNT} :
                        smcg_pkg::SMCG_OSC_WAKE_CNT;
                    if (m == smcg_pkg::SMCG_MODE_PSAVE &&
                        !async_timer_clock_select) begin
                        r_nxt.async_undef = 1'b1;
                    end
                end
            end
            smcg_pkg::SMCG_WAKE: begin
                r_nxt.cnt = r_r.cnt - 5'h01;
                if (r_r.cnt == 5'h01) begin
                    r_nxt.state = smcg_pkg::SMCG_RUN;
                end
            end
            default: r_nxt.state = smcg_pkg::SMCG_RUN;
        endcase
        if (!adc_enable) begin
            r_nxt.adc_was_off = 1'b1;
        end else if (r_r.adc_was_off) begin
            r_nxt.adc_was_off = 1'b0;
            r_nxt.adc_long_conv = 1'b1;
        end
        if (sleep_req && r_r.state == smcg_pkg::SMCG_RUN) begin
            r_nxt.async_undef = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_r <= '{state: smcg_pkg::SMCG_RUN, mode: 3'h0, cnt: 5'h00,
                     adc_was_off: 1'b0, adc_long_conv: 1'b0,
                     async_undef: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    // ------------------------------------------------------------
    // Clock, oscillator and analog controls
    // ------------------------------------------------------------
    logic asleep;
    assign asleep = r_r.state != smcg_pkg::SMCG_RUN &&
                    !(r_r.state == smcg_pkg::SMCG_WAKE &&
                      r_r.cnt == 5'h01);

    always_comb begin
        clk_en = '1;
        main_osc_en = 1'b1;
        timer_osc_en = async_timer_clock_select;
        if (sleeping) begin
            clk_en.core_clock = 1'b0;
            clk_en.program_memory_clock = 1'b0;
            if (m != smcg_pkg::SMCG_MODE_IDLE) begin
                clk_en.peripheral_io_clock = 1'b0;
            end
            if (is_deep(m)) begin
                clk_en.converter_clock = 1'b0;
                clk_en.async_timer_clock = is_async_mode(m) &&
                    async_timer_clock_select;
                timer_osc_en = is_async_mode(m) &&
                    async_timer_clock_select;
                main_osc_en = keep_osc(m);
            end
        end else if (asleep) begin
            clk_en.core_clock = 1'b0;
            clk_en.program_memory_clock = 1'b0;
        end
    end

    always_comb begin
        ana_en.adc_on = adc_enable;
        ana_en.cmp_on = cmp_enable && !(sleeping && is_deep(m));
        ana_en.bod_on = brownout_enable_fuse;
        ana_en.wdt_on = wdt_enable;
        ana_en.vref_on = brownout_enable_fuse | adc_enable |
            (cmp_enable && cmp_uses_vref);
    end

    assign input_buf_en = !(sleeping && !clk_en.peripheral_io_clock &&
                            !clk_en.converter_clock);
    assign wake_pin_buf_en = 1'b1;
    assign core_halted = asleep;
    assign wake_pulse = r_r.state == smcg_pkg::SMCG_WAKE &&
                        r_r.cnt == 5'h01;
    assign adc_long_conv = r_r.adc_long_conv;
    assign async_timer_undef = r_r.async_undef;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_permit_gates_sleep: assert property (
        @(posedge clk) disable iff (sys_rst)
        (r_r.state == smcg_pkg::SMCG_RUN && !sleep_permit_bit) |=>
        r_r.state == smcg_pkg::SMCG_RUN)
        else $error("sleep entered without permit");

    a_reserved_ignored: assert property (
        @(posedge clk) disable iff (sys_rst)
        (r_r.state == smcg_pkg::SMCG_RUN && sleep_req &&
         sleep_mode_select inside {3'h4, 3'h5}) |=>
        r_r.state == smcg_pkg::SMCG_RUN)
        else $error("reserved mode entered");

    a_idle_clocks: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && m == smcg_pkg::SMCG_MODE_IDLE) |->
        !clk_en.core_clock && clk_en.peripheral_io_clock &&
        clk_en.converter_clock)
        else $error("idle clock gating wrong");

    a_noise_clocks: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && m == smcg_pkg::SMCG_MODE_NOISE) |->
        !clk_en.peripheral_io_clock && clk_en.converter_clock)
        else $error("noise mode clock gating wrong");

    a_psave_clocks: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && m == smcg_pkg::SMCG_MODE_PSAVE) |->
        clk_en.async_timer_clock == async_timer_clock_select &&
        !clk_en.converter_clock && !main_osc_en)
        else $error("power-save clock gating wrong");

    // Wake pulse is the sixth cycle after the qualifying wake source
    a_stby_wake_six: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && m == smcg_pkg::SMCG_MODE_STBY && wake_ok) |->
        ##6 (wake_pulse && !core_halted))
        else $error("standby wake not six cycles");

    a_xstby_wake_six: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && m == smcg_pkg::SMCG_MODE_XSTBY && wake_ok) |->
        ##6 (wake_pulse && !core_halted))
        else $error("extended standby wake not six cycles");

    a_deep_cmp_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && is_deep(m)) |-> !ana_en.cmp_on)
        else $error("comparator on in deep sleep");

    a_light_cmp_kept: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && !is_deep(m)) |-> ana_en.cmp_on == cmp_enable)
        else $error("comparator setting lost in light sleep");

    a_inbuf_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && m == smcg_pkg::SMCG_MODE_PDOWN) |->
        !input_buf_en)
        else $error("input buffers on in power-down");

    // Lone edge request on either of the first two external lines
    a_edge_no_wake: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && is_deep(m) &&
         (wake_src == 10'h080 || wake_src == 10'h040)) |=> sleeping)
        else $error("edge irq woke deep sleep");

    a_halt_until_wake: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && !wake_ok) |=> (sleeping && core_halted))
        else $error("core released without wake source");

    a_wake_clocks_on: assert property (
        @(posedge clk) disable iff (sys_rst)
        (r_r.state == smcg_pkg::SMCG_WAKE) |->
        clk_en.peripheral_io_clock && clk_en.converter_clock &&
        main_osc_en)
        else $error("clocks not restored before resume");

    a_psave_undef: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleeping && m == smcg_pkg::SMCG_MODE_PSAVE &&
         !async_timer_clock_select && wake_ok) |=> async_timer_undef)
        else $error("async timer not marked undefined");

    a_adc_long_conv: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!adc_enable ##1 adc_enable) |=> adc_long_conv)
        else $error("no extended conversion after converter restart");

    a_vref_for_cmp: assert property (
        @(posedge clk) disable iff (sys_rst)
        (cmp_enable && cmp_uses_vref) |-> ana_en.vref_on)
        else $error("reference off while comparator uses it");

    a_vref_unused_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!brownout_enable_fuse && !adc_enable && !cmp_enable) |->
        !ana_en.vref_on)
        else $error("reference on with no user");

endmodule
